// ==== rtl/fcs_sequencer.sv ====
// command, execution and result phases of the floppy controller
//
// Notes on behaviour
// R01: a write or write deleted data moves each host byte to the drive in order; on a protected disk the bytes are taken but no write strobe is given.
// R02: the host writes opcode, drive byte, cyl, head, sector, size, eot, gap, data length.
// R03: write commands end with st0, st1, st2, cyl, head, sector and size.
// R04: recalibrate steps the drive to cylinder zero, then interrupts, no result.
// R05: seek steps to the new cylinder, no result bytes.
// R06: register dump gives ten bytes: four cylinders, specify, sectors, lock, config, precomp.
// R07: the host moves bytes only while the status handshake shows the matching direction.
`timescale 1ns/1ps
module fcs_sequencer #(
    parameter int SECTOR_BYTES = 128
)(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    input wire logic track0_pin,
    input wire logic write_protect_pin,
    output fcs_pkg::fcs_drive_t drive
);
    ////////////////////////////////////////////////////////////////////
    logic track0_s1, track0_s2, wp_s1, wp_s2;
    always_ff @(posedge sys_clk)
    begin
        track0_s1 <= track0_pin;
        track0_s2 <= track0_s1;
        wp_s1 <= write_protect_pin;
        wp_s2 <= wp_s1;
    end

    ////////////////////////////////////////////////////////////////////
    fcs_pkg::fcs_state_t state, next_state;
    logic [7:0] cmd [0:8];
    logic [7:0] next_cmd [0:8];
    logic [3:0] idx, next_idx, len, next_len;
    logic [7:0] res [0:9];
    logic [7:0] next_res [0:9];
    logic [7:0] cyl [0:3];
    logic [7:0] next_cyl [0:3];
    logic [7:0] target, next_target;
    logic [15:0] byte_cnt, next_byte_cnt;
    logic [15:0] step_cnt, next_step_cnt;
    logic [7:0] spec1, spec2, next_spec1, next_spec2;
    logic [7:0] cfg, precomp, next_cfg, next_precomp;
    logic [7:0] sense_st0, next_sense_st0;
    logic sense_pend, next_sense_pend;
    logic [2:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask;
    logic [7:0] rdata_q, next_rdata;
    logic irq_q;
    fcs_pkg::fcs_drive_t drv_q, next_drv;
    logic host_to_dev, dev_to_host;
    logic [2:0] ev;
    assign host_to_dev = (state == fcs_pkg::FCS_IDLE) || (state == fcs_pkg::FCS_CMD)
        || (state == fcs_pkg::FCS_EXEC_WR);
    assign dev_to_host = (state == fcs_pkg::FCS_RESULT);

    function automatic logic is_rel_seek(input logic [7:0] op);
        return op[7] && op[5:0] == fcs_pkg::OP_REL_SEEK[5:0];
    endfunction
    function automatic logic is_format(input logic [7:0] op);
        return {op[7], op[5:0]} == {2'b00, fcs_pkg::OP_FORMAT};
    endfunction
    // number of bytes a command takes, given its opcode
    function automatic logic [3:0] cmd_len(input logic [7:0] op);
        if (op[4:0] == fcs_pkg::OP_WRITE || op[4:0] == fcs_pkg::OP_WRITE_DEL)
            return fcs_pkg::RW_CMD_LEN;
        else if (op == fcs_pkg::OP_RECAL)
            return 4'h2;
        else if (op == fcs_pkg::OP_SPECIFY || op == fcs_pkg::OP_SEEK || is_rel_seek(op))
            return 4'h3;
        else if (op == fcs_pkg::OP_CONFIGURE)
            return 4'h4;
        else if (is_format(op))
            return 4'h6;
        else
            return 4'h1;
    endfunction

    always_comb
    begin
        logic wr_data, rd_data;
        logic [7:0] op;
        logic [1:0] ds;
        wr_data = reg_wr && reg_addr == fcs_pkg::A_DATA && host_to_dev; // see R07
        rd_data = reg_rd && reg_addr == fcs_pkg::A_DATA && dev_to_host; // see R07
        op = cmd[0];
        ds = cmd[1][1:0];
        next_state = state;
        next_cmd = cmd;
        next_idx = idx;
        next_len = len;
        next_res = res;
        next_cyl = cyl;
        next_target = target;
        next_byte_cnt = byte_cnt;
        next_step_cnt = step_cnt;
        next_spec1 = spec1;
        next_spec2 = spec2;
        next_cfg = cfg;
        next_precomp = precomp;
        next_sense_st0 = sense_st0;
        next_sense_pend = sense_pend;
        next_drv = drv_q;
        next_drv.step = 1'b0;
        next_drv.write_strobe = 1'b0;
        ev = 3'h0;
        case (state)
            fcs_pkg::FCS_IDLE:
            begin
                if (wr_data)
                begin
                    next_cmd[0] = reg_wdata;
                    next_len = cmd_len(reg_wdata);
                    next_idx = 4'h1;
                    next_state = fcs_pkg::FCS_CMD;
                end
            end
            fcs_pkg::FCS_CMD:
            begin
                if (idx == len)
                begin
                    next_idx = 4'h0;
                    next_drv.drive_sel = ds;
                    next_drv.head_sel = cmd[1][2];
                    if (op[4:0] == fcs_pkg::OP_WRITE || op[4:0] == fcs_pkg::OP_WRITE_DEL)
                    begin
                        next_byte_cnt = 16'(SECTOR_BYTES);
                        next_drv.write_gate = !wp_s2;
                        next_state = fcs_pkg::FCS_EXEC_WR; // see R01
                    end
                    else if (op == fcs_pkg::OP_RECAL)
                    begin
                        next_target = 8'h00; // see R04
                        next_state = fcs_pkg::FCS_STEP;
                    end
                    else if (op == fcs_pkg::OP_SEEK)
                    begin
                        next_target = cmd[2]; // see R05
                        next_state = fcs_pkg::FCS_STEP;
                    end
                    else if (is_rel_seek(op))
                    begin
                        next_target = op[6] ? cyl[ds] + cmd[2] : cyl[ds] - cmd[2];
                        next_state = fcs_pkg::FCS_STEP;
                    end
                    else if (op == fcs_pkg::OP_SPECIFY)
                    begin
                        next_spec1 = cmd[1];
                        next_spec2 = cmd[2];
                        next_state = fcs_pkg::FCS_IDLE;
                    end
                    else if (op == fcs_pkg::OP_CONFIGURE)
                    begin
                        next_cfg = cmd[2];
                        next_precomp = cmd[3];
                        next_state = fcs_pkg::FCS_IDLE;
                    end
                    else if (op == fcs_pkg::OP_SENSE_INT)
                    begin
                        next_res[0] = sense_pend ? sense_st0 : fcs_pkg::ST0_INVALID;
                        next_res[1] = cyl[sense_st0[1:0]];
                        next_sense_pend = 1'b0;
                        next_len = sense_pend ? fcs_pkg::SENSE_LEN : 4'h1;
                        next_state = fcs_pkg::FCS_RESULT;
                    end
                    else if (op == fcs_pkg::OP_DUMPREG)
                    begin
                        for (int i = 0; i < 4; i++)
                            next_res[i] = cyl[i]; // see R06
                        next_res[4] = spec1;
                        next_res[5] = spec2;
                        next_res[6] = cmd[6];
                        next_res[7] = 8'h00;
                        next_res[8] = cfg;
                        next_res[9] = precomp;
                        next_len = fcs_pkg::DUMP_LEN;
                        next_state = fcs_pkg::FCS_RESULT;
                    end
                    else if (is_format(op))
                        next_state = fcs_pkg::FCS_IDLE;
                    else
                    begin
                        next_res[0] = fcs_pkg::ST0_INVALID;
                        next_len = 4'h1;
                        ev[fcs_pkg::IRQ_INVALID] = 1'b1;
                        next_state = fcs_pkg::FCS_RESULT;
                    end
                end
                else if (wr_data)
                begin
                    next_cmd[idx] = reg_wdata; // see R02
                    next_idx = idx + 4'h1;
                end
            end
            fcs_pkg::FCS_EXEC_WR:
            begin
                if (byte_cnt == 16'h0000)
                begin
                    next_drv.write_gate = 1'b0;
                    next_res[0] = {5'h00, cmd[1][2], ds};
                    next_res[1] = {6'h00, wp_s2, 1'b0};
                    next_res[2] = 8'h00;
                    for (int i = 0; i < 4; i++)
                        next_res[3 + i] = cmd[2 + i]; // see R03
                    next_len = fcs_pkg::RW_RES_LEN;
                    ev[fcs_pkg::IRQ_CMD_DONE] = 1'b1;
                    next_state = fcs_pkg::FCS_RESULT;
                end
                else if (wr_data)
                begin
                    next_drv.write_data = reg_wdata; // see R01
                    next_drv.write_strobe = drv_q.write_gate;
                    next_byte_cnt = byte_cnt - 16'h0001;
                end
            end
            fcs_pkg::FCS_STEP:
            begin
                if (step_cnt != 16'h0000)
                    next_step_cnt = step_cnt - 16'h0001;
                else if ((op == fcs_pkg::OP_RECAL && track0_s2) || cyl[ds] == target)
                begin
                    next_cyl[ds] = target; // see R04
                    next_sense_st0 = {fcs_pkg::ST0_SEEK_END[7:3], cmd[1][2], ds};
                    next_sense_pend = 1'b1;
                    ev[fcs_pkg::IRQ_SEEK_DONE] = 1'b1; // see R05
                    next_state = fcs_pkg::FCS_IDLE;
                end
                else
                begin
                    next_drv.dir = target > cyl[ds];
                    next_drv.step = 1'b1;
                    next_cyl[ds] = target > cyl[ds] ? cyl[ds] + 8'h01 : cyl[ds] - 8'h01;
                    next_step_cnt = 16'(fcs_pkg::STEP_CYC);
                end
            end
            fcs_pkg::FCS_RESULT:
            begin
                if (rd_data)
                begin
                    if (idx + 4'h1 == len)
                    begin
                        next_idx = 4'h0;
                        next_state = fcs_pkg::FCS_IDLE;
                    end
                    else
                        next_idx = idx + 4'h1;
                end
            end
            default: next_state = fcs_pkg::FCS_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        if (reg_wr && reg_addr == fcs_pkg::A_IRQ_STATUS)
            next_irq_stat = irq_stat & ~reg_wdata[2:0];
        if (reg_wr && reg_addr == fcs_pkg::A_IRQ_MASK)
            next_irq_mask = reg_wdata[2:0];
        next_irq_stat = next_irq_stat | ev;
        next_rdata = 8'h00;
        if (reg_rd)
            case (reg_addr)
                fcs_pkg::A_DATA: next_rdata = dev_to_host ? res[idx] : 8'h00;
                fcs_pkg::A_MAIN_STATUS:
                    next_rdata = {host_to_dev | dev_to_host, dev_to_host,
                        state == fcs_pkg::FCS_EXEC_WR, state != fcs_pkg::FCS_IDLE, 4'h0};
                fcs_pkg::A_IRQ_STATUS: next_rdata = {5'h00, irq_stat};
                fcs_pkg::A_IRQ_MASK: next_rdata = {5'h00, irq_mask};
                fcs_pkg::A_CONFIG: next_rdata = cfg;
                default: next_rdata = 8'h00;
            endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            state <= fcs_pkg::FCS_IDLE;
            idx <= 4'h0;
            len <= 4'h0;
            for (int i = 0; i < 9; i++)
                cmd[i] <= 8'h00;
            for (int i = 0; i < 10; i++)
                res[i] <= 8'h00;
            for (int i = 0; i < 4; i++)
                cyl[i] <= 8'h00;
            target <= 8'h00;
            byte_cnt <= 16'h0000;
            step_cnt <= 16'h0000;
            spec1 <= 8'h00;
            spec2 <= 8'h00;
            cfg <= 8'h00;
            precomp <= 8'h00;
            sense_st0 <= 8'h00;
            sense_pend <= 1'b0;
            irq_stat <= 3'h0;
            irq_mask <= 3'h0;
            rdata_q <= 8'h00;
            irq_q <= 1'b0;
            drv_q <= '0;
        end
        else
        begin
            state <= next_state;
            idx <= next_idx;
            len <= next_len;
            cmd <= next_cmd;
            res <= next_res;
            cyl <= next_cyl;
            target <= next_target;
            byte_cnt <= next_byte_cnt;
            step_cnt <= next_step_cnt;
            spec1 <= next_spec1;
            spec2 <= next_spec2;
            cfg <= next_cfg;
            precomp <= next_precomp;
            sense_st0 <= next_sense_st0;
            sense_pend <= next_sense_pend;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            rdata_q <= next_rdata;
            irq_q <= |(next_irq_stat & next_irq_mask);
            drv_q <= next_drv;
        end
    end

    assign reg_rdata = rdata_q;
    assign irq = irq_q;
    assign drive = drv_q;
endmodule // fcs_sequencer

// ==== rtl/fcs_pkg.sv ====
// constants and types of the floppy command sequencer
package fcs_pkg;
    localparam logic [4:0] OP_WRITE = 5'h05;
    localparam logic [4:0] OP_WRITE_DEL = 5'h09;
    localparam logic [4:0] OP_FORMAT = 5'h0D;
    localparam logic [7:0] OP_RECAL = 8'h07;
    localparam logic [7:0] OP_SENSE_INT = 8'h08;
    localparam logic [7:0] OP_SPECIFY = 8'h03;
    localparam logic [7:0] OP_SEEK = 8'h0F;
    localparam logic [7:0] OP_CONFIGURE = 8'h13;
    localparam logic [6:0] OP_REL_SEEK = 7'h4F;
    localparam logic [7:0] OP_DUMPREG = 8'h0E;
    localparam logic [7:0] ST0_INVALID = 8'h80;
    localparam logic [7:0] ST0_SEEK_END = 8'h20;
    localparam logic [3:0] RW_CMD_LEN = 4'h9;
    localparam logic [3:0] RW_RES_LEN = 4'h7;
    localparam logic [3:0] DUMP_LEN = 4'hA;
    localparam logic [3:0] SENSE_LEN = 4'h2;
    localparam int STEP_NS = 1000;
    localparam int CLK_NS = 10;
    localparam int STEP_CYC = STEP_NS / CLK_NS;
    // interrupt status bits
    localparam int IRQ_CMD_DONE = 0;
    localparam int IRQ_SEEK_DONE = 1;
    localparam int IRQ_INVALID = 2;
    // register addresses
    localparam logic [3:0] A_DATA = 4'h0;
    localparam logic [3:0] A_MAIN_STATUS = 4'h1;
    localparam logic [3:0] A_IRQ_STATUS = 4'h2;
    localparam logic [3:0] A_IRQ_MASK = 4'h3;
    localparam logic [3:0] A_CONFIG = 4'h4;
    typedef enum {
        FCS_IDLE, FCS_CMD, FCS_EXEC_WR, FCS_STEP, FCS_RESULT
    } fcs_state_t;
    typedef struct packed {
        logic [7:0] cyl;
        logic [7:0] head;
        logic [7:0] sector;
        logic [7:0] size;
    } fcs_id_t;
    typedef struct packed {
        logic step;
        logic dir;
        logic head_sel;
        logic [1:0] drive_sel;
        logic write_gate;
        logic [7:0] write_data;
        logic write_strobe;
    } fcs_drive_t;
endpackage

// ==== dv/fcs_sequencer_properties.sv ====
// port assertions of the floppy command sequencer
`timescale 1ns/1ps
module fcs_sequencer_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic irq,
    input wire logic track0_pin,
    input wire logic write_protect_pin,
    input wire fcs_pkg::fcs_drive_t drive
);
    int since_step;
    int next_since_step;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    // cycles since the last step pulse, saturating
    always_comb next_since_step = drive.step ? 0 : (since_step < 1000 ? since_step + 1 : 1000);
    always_ff @(posedge sys_clk) since_step <= rst ? 1000 : next_since_step;
    ////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_step_pulse: assert property (drive.step |=> !drive.step)
        else $error("step pulse longer than one cycle");
    a_step_gap: assert property (drive.step |-> since_step >= fcs_pkg::STEP_CYC)
        else $error("step pulses too close");
    a_strobe_pulse: assert property (drive.write_strobe |=> !drive.write_strobe)
        else $error("write strobe longer than one cycle");
    a_gate_protect: assert property (write_protect_pin [*4] |-> !drive.write_gate)
        else $error("write gate on a protected disk");
    a_no_step_writing: assert property (drive.write_gate |-> !drive.step)
        else $error("head stepped while writing");
    a_mask_quiet: assert property (reg_wr && reg_addr == fcs_pkg::A_IRQ_MASK &&
        reg_wdata == 8'h00 |-> ##2 !irq) else $error("interrupt with all masked");
    a_reset_quiet: assert property ($fell(rst) |-> !irq && drive == '0 && reg_rdata == 8'h00)
        else $error("outputs not idle after reset");
    c_write: cover property (drive.write_strobe && drive.write_gate);
    c_step: cover property (drive.step && !drive.dir);
    c_irq: cover property ($rose(irq));
endmodule // fcs_sequencer_properties
bind fcs_sequencer fcs_sequencer_properties u_props (.sys_clk(sys_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .track0_pin(track0_pin),
    .write_protect_pin(write_protect_pin), .drive(drive));

// ==== dv/fcs_drive_model.sv ====
// drive model: head position, track zero and bytes written to disk
`timescale 1ns/1ps
module fcs_drive_model (
    input wire logic sys_clk,
    input wire logic rst,
    input wire fcs_pkg::fcs_drive_t drive,
    input wire logic protect,
    output logic track0_pin,
    output logic write_protect_pin,
    output int cyl,
    output int steps,
    output int wr_count,
    output logic [63:0] wr_log
);
    assign track0_pin = (cyl == 0);
    assign write_protect_pin = protect;
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            cyl <= 0;
            steps <= 0;
            wr_count <= 0;
            wr_log <= 64'h0;
        end
        else
        begin
            if (drive.step)
            begin
                steps <= steps + 1;
                cyl <= drive.dir ? cyl + 1 : (cyl > 0 ? cyl - 1 : 0);
            end
            // only gated bytes reach the medium
            if (drive.write_strobe && drive.write_gate)
            begin
                wr_count <= wr_count + 1;
                wr_log <= {wr_log[55:0], drive.write_data};
            end
        end
    end
endmodule // fcs_drive_model

// ==== dv/tb.sv ====
// self-checking bench for the floppy command sequencer
`timescale 1ns/1ps
module tb;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic protect = 1'b0;
    logic [7:0] reg_rdata;
    logic irq;
    logic track0_pin;
    logic write_protect_pin;
    fcs_pkg::fcs_drive_t drive;
    int cyl;
    int steps;
    int wr_count;
    logic [63:0] wr_log;
    int failures = 0;
    int samples_checked = 0;
    logic [7:0] d;
    logic [7:0] wr_id [7] = '{8'h06, 8'h00, 8'h03, 8'h01, 8'h09, 8'h1B, 8'hFF};
    logic [7:0] dump [10] = '{8'h00, 8'h04, 8'h00, 8'h00, 8'hA5,
        8'h4B, 8'h09, 8'h00, 8'h0A, 8'h12};
    always #5 sys_clk = ~sys_clk;
    fcs_sequencer #(.SECTOR_BYTES(4)) u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .track0_pin(track0_pin), .write_protect_pin(write_protect_pin), .drive(drive));
    fcs_drive_model u_drive (.sys_clk(sys_clk), .rst(rst), .drive(drive), .protect(protect),
        .track0_pin(track0_pin), .write_protect_pin(write_protect_pin), .cyl(cyl),
        .steps(steps), .wr_count(wr_count), .wr_log(wr_log));
    ////////////////////////////////////////////////////////////////
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED at %0t: byte %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chkn(input int g, input int e);
        samples_checked++;
        if (g != e)
        begin
            failures++;
            $display("CHECK FAILED at %0t: count %0d, expected %0d", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic ready(input logic to_host);
        logic [7:0] s;
        s = 8'h00;
        for (int n = 0; n < 500 && !(s[7] === 1'b1 && s[6] === to_host); n++)
            rd(fcs_pkg::A_MAIN_STATUS, s);
        chk8(s & 8'hC0, {1'b1, to_host, 6'h00});
    endtask
    task automatic put(input logic [7:0] v);
        ready(1'b0);
        wr(fcs_pkg::A_DATA, v);
    endtask
    task automatic get(output logic [7:0] v);
        ready(1'b1);
        rd(fcs_pkg::A_DATA, v);
    endtask
    task automatic wait_irq;
        for (int n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge sys_clk);
        chk8({7'h00, irq}, 8'h01);
    endtask
    task automatic write_sector(input logic [7:0] op, input logic prot);
        logic [7:0] v;
        int n0;
        n0 = wr_count;
        @(posedge sys_clk);
        protect <= prot;
        put(op);
        put(8'h01);
        foreach (wr_id[i]) put(wr_id[i]);
        for (int i = 0; i < 4; i++) put(8'(8'h11 * (i + 1)));
        for (int i = 0; i < 7; i++)
        begin
            get(v);
            if (i == 0) chk8(v, 8'h01);
            if (i > 2) chk8(v, wr_id[i - 3]);
        end
        rd(fcs_pkg::A_MAIN_STATUS, v);
        chk8(v & 8'hC0, 8'h80);
        chkn(wr_count, n0 + (prot ? 0 : 4));
        $display("test write op %h protect %0d done", op, prot);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        failures++;
        give_verdict();
    end
    initial
    begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rd(fcs_pkg::A_IRQ_STATUS, d);
        chk8(d, 8'h00);
        rd(fcs_pkg::A_IRQ_MASK, d);
        chk8(d, 8'h00);
        rd(4'hF, d);
        chk8(d, 8'h00);
        wr(fcs_pkg::A_IRQ_MASK, 8'h07);
        put(fcs_pkg::OP_SPECIFY);
        put(8'hA5);
        put(8'h4B);
        put(fcs_pkg::OP_CONFIGURE);
        put(8'h00);
        put(8'h0A);
        put(8'h12);
        rd(fcs_pkg::A_CONFIG, d);
        chk8(d, 8'h0A);
        $display("test reset and setup done");
        // seek drive 1 to cylinder 6, then mask, unmask, sense and clear
        put(fcs_pkg::OP_SEEK);
        put(8'h01);
        put(8'h06);
        wait_irq();
        chkn(steps, 6);
        chkn(cyl, 6);
        rd(fcs_pkg::A_MAIN_STATUS, d);
        chk8(d & 8'hC0, 8'h80);
        wr(fcs_pkg::A_IRQ_MASK, 8'h00);
        repeat (4) @(posedge sys_clk);
        chk8({7'h00, irq}, 8'h00);
        wr(fcs_pkg::A_IRQ_MASK, 8'h07);
        repeat (4) @(posedge sys_clk);
        chk8({7'h00, irq}, 8'h01);
        put(fcs_pkg::OP_SENSE_INT);
        get(d);
        chk8(d, 8'h21);
        get(d);
        chk8(d, 8'h06);
        wr(fcs_pkg::A_IRQ_STATUS, 8'h07);
        repeat (4) @(posedge sys_clk);
        chk8({7'h00, irq}, 8'h00);
        $display("test seek done");
        put(8'h8F);
        put(8'h05);
        put(8'h02);
        wait_irq();
        chkn(steps, 8);
        chkn(cyl, 4);
        chk8({5'h00, drive.head_sel, drive.drive_sel}, 8'h05);
        put(fcs_pkg::OP_SENSE_INT);
        get(d);
        chk8(d, 8'h25);
        get(d);
        chk8(d, 8'h04);
        wr(fcs_pkg::A_IRQ_STATUS, 8'h07);
        $display("test relative seek done");
        write_sector(8'h45, 1'b0);
        chk8(wr_log[7:0], 8'h44);
        chk8(wr_log[31:24], 8'h11);
        write_sector(8'h49, 1'b1);
        put(fcs_pkg::OP_DUMPREG);
        foreach (dump[i])
        begin
            get(d);
            chk8(d, dump[i]);
        end
        $display("test register dump done");
        wr(fcs_pkg::A_IRQ_STATUS, 8'h07);
        put(fcs_pkg::OP_RECAL);
        put(8'h01);
        wait_irq();
        chkn(cyl, 0);
        chkn(steps, 12);
        rd(fcs_pkg::A_MAIN_STATUS, d);
        chk8(d & 8'hC0, 8'h80);
        $display("test recalibrate done");
        for (int i = 0; i < 6; i++) put(i == 0 ? 8'h4D : 8'h00);
        rd(fcs_pkg::A_MAIN_STATUS, d);
        chk8(d & 8'hC0, 8'h80);
        $display("test format track done");
        put(8'h1F);
        get(d);
        chk8(d, fcs_pkg::ST0_INVALID);
        rd(fcs_pkg::A_IRQ_STATUS, d);
        chk8(d, 8'h06);
        $display("test invalid opcode done");
        give_verdict();
    end
endmodule // tb
